// ---- bdu_pkg.sv ----
`default_nettype none
package bdu_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_ADDR     = 8'h04;
    localparam logic [7:0] A_CONST    = 8'h08;
    localparam logic [7:0] A_ACC      = 8'h0c;
    localparam logic [7:0] A_STACK    = 8'h10;
    localparam logic [7:0] A_FLAGS    = 8'h14;
    localparam logic [7:0] A_IRQ_STAT = 8'h18;
    localparam logic [7:0] A_IRQ_MASK = 8'h1c;
    localparam logic [7:0] A_MEM_PTR  = 8'h20;
    localparam logic [7:0] A_MEM_DATA = 8'h24;

    // control register fields
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_GO_BIT  = 31;

    // operations and operand sources
    typedef enum logic [2:0] {
        OP_NONE         = 3'h0,
        OP_BCD_QUOT     = 3'h1,
        OP_BCD_QUOT_DBL = 3'h2,
        OP_FLT_QUOT     = 3'h3,
        OP_ADD_ONE      = 3'h4,
        OP_SUB_ONE      = 3'h5
    } bdu_op_t;
    typedef enum logic [1:0] {
        SRC_MEM   = 2'h0,
        SRC_PTR   = 2'h1,
        SRC_CONST = 2'h2
    } bdu_src_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } bdu_state_t;

    // flag bit positions; the irq status adds a done bit on top
    localparam int NFLAGS     = 7;
    localparam int F_ZERO     = 0;
    localparam int F_NEG      = 1;
    localparam int F_NONBCD   = 2;
    localparam int F_OVERSIZE = 3;
    localparam int F_BADPTR   = 4;
    localparam int F_BADFLT   = 5;
    localparam int F_UFLOW    = 6;
    localparam int IRQ_DONE   = 7;

    // flags touched by each operation
    localparam logic [6:0] M_QUOT     = 7'h0f;
    localparam logic [6:0] M_QUOT_DBL = 7'h07;
    localparam logic [6:0] M_FLT      = 7'h73;
    localparam logic [6:0] M_STEP     = 7'h05;

    // number limits
    localparam logic [13:0]       STEP_MAX = 14'h270f;
    localparam logic signed [9:0] BIAS_HI  = 10'sh07f;
    localparam logic signed [9:0] BIAS_LO  = 10'sh07e;
    localparam logic signed [9:0] EXP_MAX  = 10'sh0ff;

    // reset values and bus answers
    localparam logic [31:0] ACC_RST     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- bdu_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
module bdu_unit #(
    parameter int DEPTH = 256
) (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // axi4-lite write
    input  wire logic [7:0]  AWADDR_IN,
    input  wire logic        AWVALID_IN,
    output logic             AWREADY_OUT,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic [3:0]  WSTRB_IN,
    input  wire logic        WVALID_IN,
    output logic             WREADY_OUT,
    output logic [1:0]       BRESP_OUT,
    output logic             BVALID_OUT,
    input  wire logic        BREADY_IN,
    // axi4-lite read
    input  wire logic [7:0]  ARADDR_IN,
    input  wire logic        ARVALID_IN,
    output logic             ARREADY_OUT,
    output logic [31:0]      RDATA_OUT,
    output logic [1:0]       RRESP_OUT,
    output logic             RVALID_OUT,
    input  wire logic        RREADY_IN,
    // interrupt
    output logic             IRQ_OUT
);
    localparam int AW = $clog2(DEPTH);

    // byte-lane merge for a register write
    function automatic logic [31:0] strb(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic bcd_ok(input logic [31:0] x);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (x[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [26:0] bcd2bin(input logic [31:0] x);
        logic [26:0] v;
        v = '0;
        for (int i = 7; i >= 0; i--) begin
            v = v * 27'h000_000a + {23'h00_0000, x[4*i +: 4]};
        end
        return v;
    endfunction

    // double dabble; inputs stay below 10^8 so eight digits suffice
    function automatic logic [31:0] bin2bcd(input logic [26:0] b);
        logic [31:0] d;
        d = '0;
        for (int i = 26; i >= 0; i--) begin
            for (int j = 0; j < 8; j++) begin
                if (d[4*j +: 4] > 4'h4) begin
                    d[4*j +: 4] = d[4*j +: 4] + 4'h3;
                end
            end
            d = {d[30:0], b[i]};
        end
        return d;
    endfunction

    // state and registers
    bdu_pkg::bdu_state_t  state;
    bdu_pkg::bdu_op_t     op_sel;
    bdu_pkg::bdu_src_t    src_sel;
    logic [AW-1:0]        base_addr;
    logic [AW-1:0]        mem_ptr;
    logic [31:0]          cnst;
    logic [31:0]          acc;
    logic [31:0]          stack;
    logic [6:0]           flags;
    logic [7:0]           irq_stat;
    logic [7:0]           irq_mask;
    logic [15:0]          mem [DEPTH];
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;

    // bus decode; writes stall for the single execute cycle
    wire busy   = (state == bdu_pkg::ST_EXEC);
    wire wr_go  = AWVALID_IN && WVALID_IN && !bvalid && !busy;
    wire rd_go  = ARVALID_IN && !rvalid;
    wire [7:0] wa = AWADDR_IN;
    wire wr_map = (wa <= bdu_pkg::A_MEM_DATA) && (wa[1:0] == 2'b00);
    wire rd_map = (ARADDR_IN <= bdu_pkg::A_MEM_DATA) && (ARADDR_IN[1:0] == 2'b00);
    wire [31:0] ctrl_w = strb(32'h0000_0000, WDATA_IN, WSTRB_IN);
    wire [2:0] w_op  = ctrl_w[bdu_pkg::CTRL_OP_LSB +: 3];
    wire [1:0] w_src = ctrl_w[bdu_pkg::CTRL_SRC_LSB +: 2];
    wire w_const = (w_src == bdu_pkg::SRC_CONST);
    // a double divisor or a memory step never takes a constant
    wire w_legal = (w_op >= bdu_pkg::OP_BCD_QUOT) && (w_op <= bdu_pkg::OP_SUB_ONE)
                 && (w_src <= bdu_pkg::SRC_CONST)
                 && !(w_const && (w_op == bdu_pkg::OP_BCD_QUOT_DBL
                                  || w_op >= bdu_pkg::OP_ADD_ONE));
    wire start = wr_go && (wa == bdu_pkg::A_CTRL) && ctrl_w[bdu_pkg::CTRL_GO_BIT] && w_legal;

    // operand fetch: direct, through a pointer word, or constant
    wire src_ptr = (src_sel == bdu_pkg::SRC_PTR);
    wire src_k   = (src_sel == bdu_pkg::SRC_CONST);
    wire [15:0] ptr_word = mem[base_addr];
    wire ptr_bad = src_ptr && (ptr_word > 16'(DEPTH - 1));
    wire [AW-1:0] eff    = src_ptr ? ptr_word[AW-1:0] : base_addr;
    wire [AW-1:0] eff_hi = eff + AW'(1);
    wire [15:0] op16 = src_k ? cnst[15:0] : mem[eff];
    wire [31:0] op32 = src_k ? cnst : {mem[eff_hi], mem[eff]};

    // shared bcd divider for both widths
    wire is_single = (op_sel == bdu_pkg::OP_BCD_QUOT);
    wire [31:0] dvs_bcd = is_single ? {16'h0000, op16} : op32;
    wire bcd_bad = !bcd_ok(acc) || !bcd_ok(dvs_bcd);
    wire [26:0] dvd_bin = bcd2bin(acc);
    wire [26:0] dvs_bin = bcd2bin(dvs_bcd);
    wire dvs_zero = (dvs_bin == 27'h000_0000);
    wire [26:0] q_bin = dvs_zero ? 27'h000_0000 : dvd_bin / dvs_bin;
    wire [26:0] r_bin = dvs_zero ? 27'h000_0000 : dvd_bin % dvs_bin;

    // bcd step of one memory word, wrapping at the four-digit ends
    wire w_bad = !bcd_ok({16'h0000, mem[eff]});
    wire [26:0] w_full = bcd2bin({16'h0000, mem[eff]});
    wire [13:0] w_bin = w_full[13:0];
    wire is_inc = (op_sel == bdu_pkg::OP_ADD_ONE);
    wire [13:0] step_bin = is_inc ? ((w_bin == bdu_pkg::STEP_MAX) ? 14'h0000 : w_bin + 14'h0001)
                                  : ((w_bin == 14'h0000) ? bdu_pkg::STEP_MAX : w_bin - 14'h0001);
    wire [31:0] step_full = bin2bcd({13'h0000, step_bin});
    wire [15:0] step_res = step_full[15:0];

    // ieee single divide, truncating; a subnormal dividend reads as zero, a zero-exponent divisor is invalid
    wire fa_zero = (acc[30:23] == 8'h00);
    wire f_inval = (&acc[30:23]) || (&op32[30:23]) || (op32[30:23] == 8'h00);
    wire [47:0] fq = {1'b1, acc[22:0], 24'h00_0000} / {24'h00_0000, 1'b1, op32[22:0]};
    wire fq_hi = fq[24];
    wire [22:0] fman = fq_hi ? fq[23:1] : fq[22:0];
    wire signed [9:0] fexp = $signed({2'b00, acc[30:23]}) - $signed({2'b00, op32[30:23]})
                           + (fq_hi ? bdu_pkg::BIAS_HI : bdu_pkg::BIAS_LO);
    wire f_under = !fa_zero && (fexp <= 10'sh000);
    wire f_over  = (fexp >= bdu_pkg::EXP_MAX);
    wire f_sign  = acc[31] ^ op32[31];
    wire [31:0] f_res = (fa_zero || f_under) ? {f_sign, 31'h0000_0000}
                                             : {f_sign, fexp[7:0], fman};

    // result and flag selection for the execute cycle
    logic [31:0] next_acc;
    logic [31:0] next_stack;
    logic [6:0]  nf;
    logic [6:0]  fmask;
    logic        mem_wr;
    always_comb begin
        next_acc   = acc;
        next_stack = stack;
        nf         = 7'h00;
        fmask      = 7'h00;
        mem_wr     = 1'b0;
        unique case (op_sel)
            bdu_pkg::OP_BCD_QUOT, bdu_pkg::OP_BCD_QUOT_DBL: begin
                fmask = is_single ? bdu_pkg::M_QUOT : bdu_pkg::M_QUOT_DBL;
                nf[bdu_pkg::F_NONBCD]   = bcd_bad;
                nf[bdu_pkg::F_OVERSIZE] = is_single && !bcd_bad && dvs_zero;
                if (!bcd_bad && !dvs_zero && !ptr_bad) begin
                    next_acc   = bin2bcd(q_bin);
                    next_stack = bin2bcd(r_bin);
                end
                nf[bdu_pkg::F_ZERO] = (next_acc == 32'h0000_0000);
            end
            bdu_pkg::OP_FLT_QUOT: begin
                fmask = bdu_pkg::M_FLT;
                nf[bdu_pkg::F_BADPTR] = ptr_bad;
                if (!ptr_bad) begin
                    nf[bdu_pkg::F_BADFLT] = f_inval || f_over;
                    nf[bdu_pkg::F_UFLOW]  = !f_inval && f_under;
                    if (!f_inval && !f_over) begin
                        next_acc = f_res;
                    end
                end
                nf[bdu_pkg::F_ZERO] = (next_acc[30:0] == 31'h0000_0000);
                nf[bdu_pkg::F_NEG]  = next_acc[31] && (next_acc[30:0] != 31'h0000_0000);
            end
            bdu_pkg::OP_ADD_ONE, bdu_pkg::OP_SUB_ONE: begin
                fmask = bdu_pkg::M_STEP;
                nf[bdu_pkg::F_NONBCD] = w_bad;
                mem_wr = !w_bad && !ptr_bad;
                nf[bdu_pkg::F_ZERO] = mem_wr ? (step_res == 16'h0000) : (mem[eff] == 16'h0000);
            end
            default: begin
                fmask = 7'h00;
            end
        endcase
    end

    // sticky irq events; a new event beats a same-cycle clear
    wire [7:0] ev  = busy ? {1'b1, nf & fmask} : 8'h00;
    wire [7:0] clr = (wr_go && wa == bdu_pkg::A_IRQ_STAT) ? ctrl_w[7:0] : 8'h00;
    assign IRQ_OUT = |(irq_stat & irq_mask);

    // sequencer and datapath registers
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state <= bdu_pkg::ST_IDLE;
            acc   <= bdu_pkg::ACC_RST;
            stack <= bdu_pkg::ACC_RST;
            flags <= 7'h00;
        end else begin
            state <= start ? bdu_pkg::ST_EXEC : bdu_pkg::ST_IDLE;
            if (busy) begin
                acc   <= next_acc;
                stack <= next_stack;
                flags <= (flags & ~fmask) | (nf & fmask);
            end else if (wr_go && wa == bdu_pkg::A_ACC) begin
                acc <= strb(acc, WDATA_IN, WSTRB_IN);
            end else if (wr_go && wa == bdu_pkg::A_STACK) begin
                stack <= strb(stack, WDATA_IN, WSTRB_IN);
            end
        end
    end

    // software-written control and irq registers
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            op_sel    <= bdu_pkg::OP_NONE;
            src_sel   <= bdu_pkg::SRC_MEM;
            base_addr <= '0;
            mem_ptr   <= '0;
            cnst      <= 32'h0000_0000;
            irq_stat  <= 8'h00;
            irq_mask  <= 8'h00;
        end else begin
            if (start) begin
                op_sel  <= bdu_pkg::bdu_op_t'(w_op);
                src_sel <= bdu_pkg::bdu_src_t'(w_src);
            end
            if (wr_go && wa == bdu_pkg::A_ADDR) base_addr <= ctrl_w[AW-1:0];
            if (wr_go && wa == bdu_pkg::A_MEM_PTR) mem_ptr <= ctrl_w[AW-1:0];
            if (wr_go && wa == bdu_pkg::A_CONST) cnst <= strb(cnst, WDATA_IN, WSTRB_IN);
            if (wr_go && wa == bdu_pkg::A_IRQ_MASK) irq_mask <= ctrl_w[7:0];
            irq_stat <= (irq_stat & ~clr) | ev;
        end
    end

    // data memory: no reset, execute step has the port
    always_ff @(posedge CLK_IN) begin
        if (busy && mem_wr) begin
            mem[eff] <= step_res;
        end else if (wr_go && wa == bdu_pkg::A_MEM_DATA) begin
            mem[mem_ptr] <= ctrl_w[15:0];
        end
    end

    // read mux; unmapped offsets read zero
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (ARADDR_IN)
            bdu_pkg::A_CTRL:     rmux = {busy, 25'h000_0000, src_sel, 1'b0, op_sel};
            bdu_pkg::A_ADDR:     rmux = 32'(base_addr);
            bdu_pkg::A_CONST:    rmux = cnst;
            bdu_pkg::A_ACC:      rmux = acc;
            bdu_pkg::A_STACK:    rmux = stack;
            bdu_pkg::A_FLAGS:    rmux = {25'h000_0000, flags};
            bdu_pkg::A_IRQ_STAT: rmux = {24'h00_0000, irq_stat};
            bdu_pkg::A_IRQ_MASK: rmux = {24'h00_0000, irq_mask};
            bdu_pkg::A_MEM_PTR:  rmux = 32'(mem_ptr);
            bdu_pkg::A_MEM_DATA: rmux = {16'h0000, mem[mem_ptr]};
            default:             rmux = 32'h0000_0000;
        endcase
    end

    // axi response channels
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            bvalid <= 1'b0;
            bresp  <= bdu_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= bdu_pkg::RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_map ? bdu_pkg::RESP_OKAY : bdu_pkg::RESP_SLVERR;
            end else if (BREADY_IN) begin
                bvalid <= 1'b0;
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rmux;
                rresp  <= rd_map ? bdu_pkg::RESP_OKAY : bdu_pkg::RESP_SLVERR;
            end else if (RREADY_IN) begin
                rvalid <= 1'b0;
            end
        end
    end

    assign AWREADY_OUT = wr_go;
    assign WREADY_OUT  = wr_go;
    assign BVALID_OUT  = bvalid;
    assign BRESP_OUT   = bresp;
    assign ARREADY_OUT = !rvalid;
    assign RVALID_OUT  = rvalid;
    assign RDATA_OUT   = rdata;
    assign RRESP_OUT   = rresp;

    wire x_quot = busy && (op_sel <= bdu_pkg::OP_BCD_QUOT_DBL) && !bcd_bad && !dvs_zero
                  && !ptr_bad;

    chk_quot_pair: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        x_quot |=> bcd2bin(acc) * $past(dvs_bin) + bcd2bin(stack) == $past(dvd_bin))
        else $error("quotient and remainder do not rebuild dividend");
    chk_oversize: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && is_single && !bcd_bad && dvs_zero |=> flags[3] && $stable(acc))
        else $error("zero divisor not flagged as oversize");
    chk_zero_flag: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && op_sel <= bdu_pkg::OP_BCD_QUOT_DBL |=> flags[0] == (acc == 32'h0000_0000))
        else $error("zero flag disagrees with accumulator");
    chk_neg_real: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && op_sel == bdu_pkg::OP_FLT_QUOT |=> flags[1] == (acc[31] && |acc[30:0]))
        else $error("negative flag disagrees with accumulator");
    chk_nonbcd_keep: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && op_sel <= bdu_pkg::OP_BCD_QUOT_DBL && bcd_bad |=> flags[2] && $stable(acc))
        else $error("bad digit not flagged or result written");
    chk_flag_hold: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !busy |=> $stable(flags))
        else $error("flags moved without an operation");
    chk_ptr_bad: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && op_sel == bdu_pkg::OP_FLT_QUOT && ptr_bad |=> flags[4] && $stable(acc))
        else $error("bad pointer not flagged");
    chk_uflow_zero: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && op_sel == bdu_pkg::OP_FLT_QUOT && !ptr_bad && !f_inval && f_under
        |=> flags[6] && acc[30:0] == 31'h0000_0000)
        else $error("underflow not flagged or not flushed");
    chk_step_value: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        busy && mem_wr |-> (bcd2bin({16'h0000, step_res}) + (is_inc ? 27'h000_0000
        : 27'h000_0001)) % 27'h000_2710 == (w_full + (is_inc ? 27'h000_0001
        : 27'h000_0000)) % 27'h000_2710)
        else $error("memory step is not one count");
    chk_exec_once: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        start |=> busy ##1 !busy)
        else $error("execute cycle not exactly one");
endmodule
`default_nettype wire

// ---- bcd_real_divide_incdec_unit_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module bcd_real_divide_incdec_unit_bench;
    // one operation with its operand and the results it should leave
    typedef struct packed {
        logic [2:0]  op;
        logic [1:0]  src;
        logic [31:0] acc;
        logic [31:0] opnd;
        logic [31:0] eacc;
        logic [31:0] e2;
        logic [6:0]  eflg;
    } bdu_row_t;
    // bus master side, all driven just after the rising edge
    logic             clk         = 1'b0;
    logic             srst        = 1'b1;
    logic [7:0]       awaddr      = 8'h00;
    logic [7:0]       araddr      = 8'h00;
    logic [31:0]      wdata       = 32'h0000_0000;
    logic             awvalid     = 1'b0;
    logic             wvalid      = 1'b0;
    logic             bready      = 1'b0;
    logic             arvalid     = 1'b0;
    logic             rready      = 1'b0;
    wire logic        awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    logic [31:0]      rd_val;
    logic [1:0]       rsp;
    logic [1:0]       wresp;
    int               fails       = 0;
    int               check_count = 0;

    bdu_unit #(.DEPTH(256)) bdu_unit_i (
        .CLK_IN(clk), .SRST_IN(srst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
        .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
        .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .IRQ_OUT(irq)
    );

    // 50 MHz clock
    initial forever #10 clk = ~clk;

    // ordinary cases: bcd and real divides, steps with wrap at both ends
    bdu_row_t rows [14] = '{
        '{3'h1, 2'h1, 32'h0000_0100, 32'h0000_0007, 32'h0000_0014, 32'h0000_0002, 7'h00},
        '{3'h1, 2'h2, 32'h1234_5678, 32'h0000_9999, 32'h0000_1234, 32'h0000_6912, 7'h00},
        '{3'h1, 2'h0, 32'h0000_0042, 32'h0000_0000, 32'h0000_0042, 32'h0000_0000, 7'h08},
        '{3'h1, 2'h0, 32'h0000_0005, 32'h0000_0007, 32'h0000_0000, 32'h0000_0005, 7'h01},
        '{3'h1, 2'h0, 32'h0000_00a0, 32'h0000_0007, 32'h0000_00a0, 32'h0000_0000, 7'h04},
        '{3'h2, 2'h1, 32'h1234_5678, 32'h0000_0100, 32'h0012_3456, 32'h0000_0078, 7'h00},
        '{3'h3, 2'h2, 32'h40c0_0000, 32'h4000_0000, 32'h4040_0000, 32'h0000_0000, 7'h00},
        '{3'h3, 2'h0, 32'hc0c0_0000, 32'h4000_0000, 32'hc040_0000, 32'h0000_0000, 7'h02},
        '{3'h3, 2'h2, 32'h0080_0000, 32'h4000_0000, 32'h0000_0000, 32'h0000_0000, 7'h41},
        '{3'h3, 2'h2, 32'h7fc0_0000, 32'h4000_0000, 32'h7fc0_0000, 32'h0000_0000, 7'h20},
        '{3'h4, 2'h0, 32'h0000_0077, 32'h0000_0009, 32'h0000_0077, 32'h0000_0010, 7'h00},
        '{3'h4, 2'h1, 32'h0000_0077, 32'h0000_9999, 32'h0000_0077, 32'h0000_0000, 7'h01},
        '{3'h5, 2'h0, 32'h0000_0077, 32'h0000_0000, 32'h0000_0077, 32'h0000_9999, 7'h00},
        '{3'h5, 2'h0, 32'h0000_0077, 32'h0000_00a0, 32'h0000_0077, 32'h0000_00a0, 7'h04}
    };

    // only the flags an operation owns are compared per row
    function automatic logic [6:0] mask(input logic [2:0] op);
        case (op)
            3'h1: mask = bdu_pkg::M_QUOT;
            3'h2: mask = bdu_pkg::M_QUOT_DBL;
            3'h3: mask = bdu_pkg::M_FLT;
            default: mask = bdu_pkg::M_STEP;
        endcase
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic timed_out;
        fails++;
        $display("wrong value bus wait expected answer seen none");
        stop_test();
    endtask

    // address and data offered together; bready up early so the answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do @(posedge clk) n++; while (awready !== 1'b1 && n < 50);
        `CHK("write ready", 1'b1, wready);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        while (bvalid !== 1'b1 && n < 50) @(posedge clk) n++;
        wresp = bresp;
        bready <= 1'b0;
        if (n >= 50) timed_out();
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do @(posedge clk) n++; while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 50) @(posedge clk) n++;
        rd_val = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n >= 50) timed_out();
    endtask

    // memory is reached indirectly through the pointer register
    task automatic mem_wr(input logic [7:0] a, input logic [15:0] d);
        wr(bdu_pkg::A_MEM_PTR, {24'h00_0000, a});
        wr(bdu_pkg::A_MEM_DATA, {16'h0000, d});
    endtask

    // operand at 0x10; for pointer source 0x10 points at 0x30
    task automatic run_row(input bdu_row_t r);
        logic [7:0] ea;
        logic [6:0] m;
        ea = (r.src == 2'h1) ? 8'h30 : 8'h10;
        m = mask(r.op);
        mem_wr(8'h10, (r.src == 2'h1) ? 16'h0030 : r.opnd[15:0]);
        mem_wr(8'h11, r.opnd[31:16]);
        mem_wr(8'h30, r.opnd[15:0]);
        mem_wr(8'h31, r.opnd[31:16]);
        wr(bdu_pkg::A_ADDR, 32'h0000_0010);
        wr(bdu_pkg::A_CONST, r.opnd);
        wr(bdu_pkg::A_ACC, r.acc);
        wr(bdu_pkg::A_STACK, 32'h0000_0000);
        wr(bdu_pkg::A_CTRL, {1'b1, 25'h000_0000, r.src, 1'b0, r.op});
        `CHK("control answer", bdu_pkg::RESP_OKAY, wresp);
        rd(bdu_pkg::A_ACC);
        `CHK("acc", r.eacc, rd_val);
        if (r.op >= 3'h4) begin
            wr(bdu_pkg::A_MEM_PTR, {24'h00_0000, ea});
            rd(bdu_pkg::A_MEM_DATA);
            `CHK("memory", r.e2[15:0], rd_val[15:0]);
        end else begin
            rd(bdu_pkg::A_STACK);
            `CHK("stack", r.e2, rd_val);
        end
        rd(bdu_pkg::A_FLAGS);
        `CHK("flags", r.eflg & m, rd_val[6:0] & m);
    endtask

    // reset, table, then hand-written cases
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(bdu_pkg::A_ACC);
        `CHK("acc after reset", 32'h0000_0000, rd_val);
        rd(bdu_pkg::A_IRQ_MASK);
        `CHK("mask after reset", 32'h0000_0000, rd_val);
        `CHK("irq after reset", 1'b0, irq);
        $display("test reset done");
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("test row %0d done", i);
        end
        // a step does not own the oversize flag, so it must survive
        run_row(rows[2]);
        run_row(rows[10]);
        rd(bdu_pkg::A_FLAGS);
        `CHK("held oversize", 1'b1, rd_val[3]);
        $display("test flag hold done");
        // pointer word beyond memory aborts the real divide
        mem_wr(8'h10, 16'h0100);
        wr(bdu_pkg::A_ACC, 32'h4000_0000);
        wr(bdu_pkg::A_CTRL, 32'h8000_0013);
        rd(bdu_pkg::A_FLAGS);
        `CHK("bad pointer", 1'b1, rd_val[4]);
        rd(bdu_pkg::A_ACC);
        `CHK("acc kept", 32'h4000_0000, rd_val);
        $display("test bad pointer done");
        // constant divisor for the double divide is ignored, no done event
        wr(bdu_pkg::A_IRQ_STAT, 32'h0000_00ff);
        wr(bdu_pkg::A_ACC, 32'h0000_0055);
        wr(bdu_pkg::A_CTRL, 32'h8000_0022);
        rd(bdu_pkg::A_ACC);
        `CHK("acc untouched", 32'h0000_0055, rd_val);
        rd(bdu_pkg::A_IRQ_STAT);
        `CHK("no done event", 32'h0000_0000, rd_val);
        $display("test refused start done");
        // done interrupt raised, cleared by writing one, then masked
        wr(bdu_pkg::A_IRQ_MASK, 32'h0000_0080);
        run_row(rows[0]);
        `CHK("irq raised", 1'b1, irq);
        wr(bdu_pkg::A_IRQ_STAT, 32'h0000_0080);
        `CHK("irq cleared", 1'b0, irq);
        wr(bdu_pkg::A_IRQ_MASK, 32'h0000_0000);
        run_row(rows[0]);
        `CHK("irq masked", 1'b0, irq);
        $display("test interrupt done");
        // unmapped and unaligned places answer with an error
        rd(8'h28);
        `CHK("unmapped read", bdu_pkg::RESP_SLVERR, rsp);
        rd(8'h05);
        `CHK("unaligned read", bdu_pkg::RESP_SLVERR, rsp);
        wr(8'h2c, 32'h0000_0001);
        `CHK("unmapped write", bdu_pkg::RESP_SLVERR, wresp);
        $display("test unmapped done");
        // reset in mid-run clears the accumulator again
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(bdu_pkg::A_ACC);
        `CHK("acc after second reset", 32'h0000_0000, rd_val);
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire
